// ===== smruc_pkg.sv
// Shared constants and carrier types for the switch monitor reset and supply control block
`default_nettype none

package smruc_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_CONFIG   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CLEAN    = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IN_EN    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_EVENT    = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_MISC     = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CHECKSUM = 8'h14;

    // ------------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------------
    localparam int CFG_RUN     = 0;
    localparam int CFG_CHK_REQ = 1;
    localparam int CFG_SRST    = 2;
    localparam int CLEAN_W     = 8;
    localparam int IN_EN_W     = 24;
    localparam int EV_POR      = 0;
    localparam int EV_SELFCHK  = 1;
    localparam int EV_LOW_SUP  = 2;
    localparam int EV_SW_CHG   = 3;
    localparam int EV_W        = 4;
    localparam int MISC_LIVE   = 0;
    localparam int MISC_MON    = 1;
    localparam int CHK_W       = 8;
    localparam int SO_W        = 8;
    localparam int SO_POR      = 7;
    localparam int SO_OTHER    = 6;
    localparam int SO_CHKERR   = 5;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [EV_W-1:0]    EV_RESET    = 4'h0;
    localparam logic [IN_EN_W-1:0] IN_EN_RESET = 24'h00_0000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int REACT_MAX_US  = 20;
    localparam int REACT_CYCLES  = (REACT_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam int INIT_CYCLES   = 16;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_HOLD  = 2'b00,
        ST_INIT  = 2'b01,
        ST_CHECK = 2'b10,
        ST_READY = 2'b11
    } smruc_state_e;

    typedef struct packed {
        logic              we;
        logic              re;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } smruc_bus_req_s;

    typedef struct packed {
        logic por_ok;
        logic reset_pin;
        logic uv_low;
        logic logic_ok;
    } smruc_supply_s;

endpackage : smruc_pkg

`default_nettype wire

// ===== smruc_control.sv
// Power-on, reset, run control and supply under-voltage logic of the switch monitor
//
// Summary of operation
// - Hold reset until supply above power-on threshold
// - After init: event line low, power-on flag
// - Self-check failure sets error flag with power-on
// - Run bit set by host starts monitoring
// - Config writes ignored while running, listed exceptions
// - Clearing run bit stops wetting and monitoring
// - Checksum stays usable while running
// - Supply below power-on threshold: full restart
// - Reset pin high stops all, clears registers
// - Reset pin low: reinit, then power-on event
// - Software reset bit reinitialises with power-on event
// - Logic supply loss stops serial, keeps registers
// - Under-voltage turns off currents and monitoring
// - Under-voltage entry: event, flags, serial other-event
// - Event register cleared on chip-select rise if read
// - Serial and registers stay alive in under-voltage
// - One interrupt per under-voltage, none after clear
// - Recovery: event line low, flag set, live cleared
// - Recovery resumes polling from first channel
// - First poll cycle raises change event, baseline
// - Event line low within twenty microseconds
`timescale 1ns/1ps
`default_nettype none

module smruc_control #(
    parameter int INIT_LEN = smruc_pkg::INIT_CYCLES
) (
    // Clock and reset
    input  wire logic                           clk,
    input  wire logic                           reset_n,
    // Register port
    input  wire smruc_pkg::smruc_bus_req_s      bus_req,
    output logic [smruc_pkg::DATA_W-1:0]        rdata,
    // Supply and reset pin comparators, asynchronous
    input  wire smruc_pkg::smruc_supply_s       supply,
    // Serial link pins, asynchronous
    input  wire logic                           cs_n,
    input  wire logic                           sclk,
    output logic                                so_data,
    output logic                                so_oe,
    // Factory settings loader and polling engine
    input  wire logic                           factory_check_err,
    input  wire logic                           poll_cycle_done,
    // Controls and event line
    output logic                                wetting_enable,
    output logic                                poll_restart,
    output logic                                baseline_capture,
    output logic [smruc_pkg::IN_EN_W-1:0]       input_enable,
    output logic [smruc_pkg::CLEAN_W-1:0]       clean_pulse_config_one,
    output logic                                event_line_n
);
    import smruc_pkg::*;

    localparam int CNT_W = $clog2(INIT_LEN + 1);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        smruc_supply_s sup_s1;
        smruc_supply_s sup_s2;
        logic          cs_s1;
        logic          cs_s2;
        logic          cs_d;
        logic          sclk_s1;
        logic          sclk_s2;
        logic          sclk_d;
    } smruc_pins_s;

    typedef struct packed {
        smruc_pins_s          pins;
        smruc_state_e         fsm;
        logic [CNT_W-1:0]     init_cnt;
        logic                 run;
        logic                 mon;
        logic [CLEAN_W-1:0]   clean_cfg;
        logic [IN_EN_W-1:0]   in_en;
        logic [CHK_W-1:0]     chk_value;
        logic [EV_W-1:0]      events;
        logic                 live;
        logic                 ev_read;
        logic                 await_poll;
        logic                 poll_restart;
        logic                 baseline;
        logic [SO_W-1:0]      so_shift;
        logic [DATA_W-1:0]    rdata;
    } smruc_regs_s;

    smruc_regs_s          st;
    smruc_regs_s          next_st;
    smruc_pins_s          pins_keep;
    logic [EV_W-1:0]      ev_set;
    logic [EV_W-1:0]      ev_clr;
    logic                 por_ok;
    logic                 rst_pin;
    logic                 uv;
    logic                 lok;
    logic                 cs_act;
    logic                 cs_rise;
    logic                 cs_fall;
    logic                 sclk_fall;
    logic                 ready;
    logic                 wr;
    logic                 rd;
    logic                 soft_rst;
    logic                 hold;
    logic [CHK_W-1:0]     checksum;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        pins_keep = '0;
        ev_set = '0;
        ev_clr = '0;

        // Only the second stage of each synchroniser, plus the chip-select and clock delay stages, is read below
        next_st.pins.sup_s1  = supply;
        next_st.pins.sup_s2  = st.pins.sup_s1;
        next_st.pins.cs_s1   = cs_n;
        next_st.pins.cs_s2   = st.pins.cs_s1;
        next_st.pins.cs_d    = st.pins.cs_s2;
        next_st.pins.sclk_s1 = sclk;
        next_st.pins.sclk_s2 = st.pins.sclk_s1;
        next_st.pins.sclk_d  = st.pins.sclk_s2;

        por_ok    = st.pins.sup_s2.por_ok;
        rst_pin   = st.pins.sup_s2.reset_pin;
        uv        = st.pins.sup_s2.uv_low;
        lok       = st.pins.sup_s2.logic_ok;
        cs_act    = !st.pins.cs_s2;
        cs_rise   = st.pins.cs_s2 && !st.pins.cs_d;
        cs_fall   = !st.pins.cs_s2 && st.pins.cs_d;
        sclk_fall = !st.pins.sclk_s2 && st.pins.sclk_d;
        ready     = (st.fsm == ST_READY);

        // Serial access needs the logic supply; under-voltage does not block it
        wr = bus_req.we && ready && lok;
        rd = bus_req.re && ready && lok;
        soft_rst = wr && (bus_req.addr == OFS_CONFIG) && bus_req.wdata[CFG_SRST];
        checksum = st.in_en[23:16] ^ st.in_en[15:8] ^ st.in_en[7:0] ^ st.clean_cfg;

        next_st.poll_restart = 1'b0;
        next_st.baseline = 1'b0;
        next_st.rdata = '0;

        // --------------------------------------------------------------
        // Initialisation sequence
        // --------------------------------------------------------------
        case (st.fsm)
            ST_HOLD: begin
                next_st.init_cnt = '0;
                if (por_ok && !rst_pin) begin
                    next_st.fsm = ST_INIT;
                end
            end
            ST_INIT: begin
                next_st.init_cnt = st.init_cnt + CNT_W'(1);
                if (st.init_cnt == CNT_W'(INIT_LEN - 1)) begin
                    next_st.fsm = ST_CHECK;
                end
            end
            ST_CHECK: begin
                ev_set[EV_POR] = 1'b1;
                ev_set[EV_SELFCHK] = factory_check_err;
                next_st.fsm = ST_READY;
            end
            ST_READY: begin
                // Entry and exit are edges only, so a cleared flag stays clear
                if (uv && !st.live) begin
                    ev_set[EV_LOW_SUP] = 1'b1;
                    next_st.live = 1'b1;
                end else if (!uv && st.live) begin
                    ev_set[EV_LOW_SUP] = 1'b1;
                    next_st.live = 1'b0;
                    next_st.poll_restart = 1'b1;
                    next_st.await_poll = 1'b1;
                end
                if (st.await_poll && poll_cycle_done) begin
                    ev_set[EV_SW_CHG] = 1'b1;
                    next_st.baseline = 1'b1;
                    next_st.await_poll = 1'b0;
                end
            end
            default: begin
                next_st.fsm = ST_HOLD;
            end
        endcase

        // --------------------------------------------------------------
        // Register writes
        // --------------------------------------------------------------
        if (wr) begin
            case (bus_req.addr)
                OFS_CONFIG: begin
                    next_st.run = bus_req.wdata[CFG_RUN];
                    if (bus_req.wdata[CFG_CHK_REQ]) begin
                        next_st.chk_value = checksum;
                    end
                end
                OFS_CLEAN: begin
                    next_st.clean_cfg = bus_req.wdata[CLEAN_W-1:0];
                end
                OFS_IN_EN: begin
                    if (!st.run) begin
                        next_st.in_en = bus_req.wdata[IN_EN_W-1:0];
                    end
                end
                default: begin
                    next_st.run = st.run;
                end
            endcase
        end

        // --------------------------------------------------------------
        // Register reads, data in the following cycle
        // --------------------------------------------------------------
        if (rd) begin
            case (bus_req.addr)
                OFS_CONFIG:   next_st.rdata[CFG_RUN] = st.run;
                OFS_CLEAN:    next_st.rdata[CLEAN_W-1:0] = st.clean_cfg;
                OFS_IN_EN:    next_st.rdata[IN_EN_W-1:0] = st.in_en;
                OFS_EVENT:    next_st.rdata[EV_W-1:0] = st.events;
                OFS_MISC: begin
                    next_st.rdata[MISC_LIVE] = st.live;
                    next_st.rdata[MISC_MON] = st.mon;
                end
                OFS_CHECKSUM: next_st.rdata[CHK_W-1:0] = st.chk_value;
                default:      next_st.rdata = '0;
            endcase
            if (bus_req.addr == OFS_EVENT && cs_act) begin
                next_st.ev_read = 1'b1;
            end
        end

        // --------------------------------------------------------------
        // Frame end and event flags; a new event beats the clear
        // --------------------------------------------------------------
        if (cs_rise) begin
            if (st.ev_read) begin
                ev_clr = '1;
            end
            next_st.ev_read = 1'b0;
        end
        next_st.events = (st.events & ~ev_clr) | ev_set;

        // --------------------------------------------------------------
        // Serial status byte, loaded at frame start
        // --------------------------------------------------------------
        if (cs_fall) begin
            next_st.so_shift = '0;
            next_st.so_shift[SO_POR] = st.events[EV_POR];
            next_st.so_shift[SO_OTHER] = st.live || st.events[EV_LOW_SUP];
            next_st.so_shift[SO_CHKERR] = st.events[EV_SELFCHK];
        end else if (sclk_fall && cs_act) begin
            next_st.so_shift = {st.so_shift[SO_W-2:0], 1'b0};
        end

        // Wetting current only with run set, ready and supply healthy
        next_st.mon = next_st.run && !next_st.live && (next_st.fsm == ST_READY);

        // --------------------------------------------------------------
        // Any reset source clears everything but the synchronisers
        // --------------------------------------------------------------
        hold = !por_ok || rst_pin || soft_rst;
        if (hold) begin
            pins_keep = next_st.pins;
            next_st = '0;
            next_st.pins = pins_keep;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // Chip select idles high; a low reset value would fake a frame end
            st <= '0;
            st.pins.cs_s1 <= 1'b1;
            st.pins.cs_s2 <= 1'b1;
            st.pins.cs_d  <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rdata                  = st.rdata;
    assign so_data                = st.so_shift[SO_W-1];
    assign so_oe                  = !st.pins.cs_s2 && st.pins.sup_s2.logic_ok
                                    && (st.fsm == ST_READY);
    assign wetting_enable         = st.mon;
    assign poll_restart           = st.poll_restart;
    assign baseline_capture       = st.baseline;
    assign input_enable           = st.in_en;
    assign clean_pulse_config_one = st.clean_cfg;
    assign event_line_n           = (st.events == EV_RESET);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Cycles the event line has stayed high while a supply event waits
    logic [15:0] react_cnt;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            react_cnt <= '0;
        end else if (ready && (uv != st.live) && event_line_n) begin
            react_cnt <= react_cnt + 16'h0001;
        end else begin
            react_cnt <= '0;
        end
    end

    sequence s_run_write;
        wr && bus_req.addr == OFS_CONFIG && bus_req.wdata[CFG_RUN] && !soft_rst;
    endsequence

    sequence s_soft_write;
        soft_rst && por_ok && !rst_pin;
    endsequence

    a_hold_below_por: assert property (
        !por_ok |=> st.fsm == ST_HOLD && !st.run && st.in_en == IN_EN_RESET
    ) else $error("not held in reset below power-on threshold");

    a_init_por_event: assert property (
        st.fsm == ST_CHECK && !hold |=> st.events[EV_POR] && !event_line_n
    ) else $error("power-on event missing after init");

    a_selfcheck_error: assert property (
        st.fsm == ST_CHECK && !hold && factory_check_err |=> st.events[EV_SELFCHK]
    ) else $error("self-check error not flagged");

    a_run_starts_mon: assert property (
        s_run_write ##0 (!uv && !st.live && !hold) |=> st.run ##0 st.mon
    ) else $error("monitoring did not start after run write");

    a_config_locked: assert property (
        st.run && wr && bus_req.addr == OFS_IN_EN && !hold |=> $stable(st.in_en)
    ) else $error("input enable changed while running");

    a_soft_reinit: assert property (
        s_soft_write |=> st.fsm == ST_HOLD ##1 st.fsm == ST_INIT
    ) else $error("software reset did not reinitialise");

    a_uv_entry: assert property (
        ready && uv && !st.live && !hold |=> st.live && st.events[EV_LOW_SUP] && !wetting_enable
    ) else $error("under-voltage entry handling wrong");

    a_event_clear: assert property (
        cs_rise && st.ev_read && !hold |=> st.events == $past(ev_set)
    ) else $error("event register not cleared at frame end");

    a_uv_exit: assert property (
        ready && !uv && st.live && !hold |=> !st.live && st.poll_restart && !event_line_n
    ) else $error("under-voltage recovery handling wrong");

    a_first_poll: assert property (
        ready && st.await_poll && poll_cycle_done && !hold |=> st.baseline && st.events[EV_SW_CHG]
    ) else $error("first poll after recovery not reported");

    a_react_bound: assert property (
        react_cnt < 16'(REACT_CYCLES)
    ) else $error("event line late after supply event");

    a_run_zero_reset: assert property (
        st.fsm == ST_HOLD |-> !st.run && !wetting_enable
    ) else $error("run bit set during reset");

endmodule : smruc_control

`default_nettype wire

// ===== smruc_host_model.sv
// Behavioural host controller on the serial side of the switch monitor
`timescale 1ns/1ps
`default_nettype none

module smruc_host_model (
    // Serial pins
    input  wire logic so_data,
    input  wire logic so_oe,
    output logic      cs_n,
    output logic      sclk
);
    logic [7:0] status;

    initial begin
        cs_n   = 1'b1;
        sclk   = 1'b0;
        status = 8'h00;
    end

    // Clock stands still outside frames; 3 ns offset keeps edges clear of clk
    task automatic open_frame;
        #3 cs_n = 1'b0;
        #64;
        repeat (8) begin
            sclk = 1'b1;
            // A released line shows the inverse of the last bit, never a guess
            status = {status[6:0], so_oe ? so_data : ~status[0]};
            #32 sclk = 1'b0;
            #32;
        end
    endtask : open_frame

    task automatic close_frame;
        #3 cs_n = 1'b1;
    endtask : close_frame
endmodule : smruc_host_model

`default_nettype wire

// ===== switch_monitor_reset_uv_control_bench.sv
// Self-checking bench for the switch monitor reset and supply control block
`timescale 1ns/1ps
`default_nettype none

module switch_monitor_reset_uv_control_bench;
    import smruc_pkg::*;
    logic                 clk, reset_n, cs_n, sclk, so_data, so_oe, chk_err, poll_done;
    logic                 wet, restart, base, ev_n;
    smruc_bus_req_s       bus_req;
    smruc_supply_s        supply;
    logic [DATA_W-1:0]    rdata, rd;
    logic [IN_EN_W-1:0]   in_en;
    logic [CLEAN_W-1:0]   clean;
    int                   fails, check_count, cycles, n;

    smruc_control #(.INIT_LEN(2)) dut (.clk(clk), .reset_n(reset_n), .bus_req(bus_req),
        .rdata(rdata), .supply(supply), .cs_n(cs_n), .sclk(sclk), .so_data(so_data),
        .so_oe(so_oe), .factory_check_err(chk_err), .poll_cycle_done(poll_done),
        .wetting_enable(wet), .poll_restart(restart), .baseline_capture(base),
        .input_enable(in_en), .clean_pulse_config_one(clean), .event_line_n(ev_n));
    smruc_host_model host (.so_data(so_data), .so_oe(so_oe), .cs_n(cs_n), .sclk(sclk));

    // ------------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            close_out;
        end
    end

    task automatic close_out;
        if (fails == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic idle(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : idle

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk) bus_req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
        @(posedge clk) bus_req.we <= 1'b0;
    endtask : wr

    task automatic rd_reg(input logic [ADDR_W-1:0] a);
        @(posedge clk) bus_req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(posedge clk) bus_req.re <= 1'b0;
        #1 rd = rdata;
    endtask : rd_reg

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        rd_reg(a);
        chk(rd, e);
    endtask : rd_chk

    // Status byte is judged, then the event register is read inside the frame
    task automatic frame(input logic [7:0] st);
        host.open_frame;
        chk({24'h0000_00, host.status}, {24'h0000_00, st});
        rd_reg(OFS_EVENT);
        host.close_frame;
        idle(8);
    endtask : frame

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_power_up;
        chk(ev_n, 0);
        rd_chk(OFS_EVENT, 32'h0000_0001);
        rd_chk(OFS_CONFIG, 32'h0000_0000);
        chk(wet, 0);
        idle(4);
        chk(ev_n, 0);
        frame(8'h80);
        chk(ev_n, 1);
        rd_chk(OFS_EVENT, 32'h0000_0000);
    endtask : t_power_up

    task automatic t_selfcheck;
        @(posedge clk) chk_err <= 1'b1;
        wr(OFS_CONFIG, 32'h0000_0004);
        idle(30);
        chk(ev_n, 0);
        rd_chk(OFS_EVENT, 32'h0000_0003);
        frame(8'hA0);
        @(posedge clk) chk_err <= 1'b0;
        wr(OFS_CONFIG, 32'h0000_0004);
        idle(30);
        frame(8'h80);
    endtask : t_selfcheck

    task automatic t_run_lock;
        wr(OFS_IN_EN, 32'h0012_3456);
        wr(OFS_CONFIG, 32'h0000_0001);
        idle(1);
        chk(wet, 1);
        wr(OFS_IN_EN, 32'h00FF_FFFF);
        rd_chk(OFS_IN_EN, 32'h0012_3456);
        wr(OFS_CLEAN, 32'h0000_00A5);
        rd_chk(OFS_CLEAN, 32'h0000_00A5);
        chk(clean, 8'hA5);
        wr(OFS_CONFIG, 32'h0000_0003);
        rd_chk(OFS_CHECKSUM, {24'h0000_00, 8'h12 ^ 8'h34 ^ 8'h56 ^ 8'hA5});
        chk(in_en, 24'h12_3456);
        wr(OFS_CONFIG, 32'h0000_0000);
        idle(1);
        chk(wet, 0);
        wr(OFS_IN_EN, 32'h0000_00F0);
        rd_chk(OFS_IN_EN, 32'h0000_00F0);
        wr(OFS_CONFIG, 32'h0000_0001);
        idle(1);
        chk(wet, 1);
    endtask : t_run_lock

    task automatic t_uv;
        @(posedge clk) supply.uv_low <= 1'b1;
        n = 0;
        while (ev_n !== 1'b0 && n < REACT_CYCLES) begin
            idle(1);
            n++;
        end
        chk(n < REACT_CYCLES, 1);
        idle(2);
        chk(wet, 0);
        rd_chk(OFS_EVENT, 32'h0000_0004);
        rd_chk(OFS_MISC, 32'h0000_0001);
        rd_chk(OFS_IN_EN, 32'h0000_00F0);
        frame(8'h40);
        idle(40);
        chk(ev_n, 1);
        frame(8'h40);
        @(posedge clk) supply.uv_low <= 1'b0;
        n = 0;
        while (restart !== 1'b1 && n < 20) begin
            idle(1);
            n++;
        end
        chk(restart, 1);
        idle(2);
        chk(ev_n, 0);
        chk(wet, 1);
        rd_chk(OFS_MISC, 32'h0000_0002);
        @(posedge clk) poll_done <= 1'b1;
        @(posedge clk) poll_done <= 1'b0;
        // The baseline pulse stands only in the cycle after this edge
        #1;
        n = 0;
        while (base !== 1'b1 && n < 5) begin
            idle(1);
            n++;
        end
        chk(base, 1);
        rd_chk(OFS_EVENT, 32'h0000_000C);
        frame(8'h40);
    endtask : t_uv

    task automatic t_logic_loss;
        @(posedge clk) supply.logic_ok <= 1'b0;
        idle(5);
        host.open_frame;
        chk(so_oe, 0);
        host.close_frame;
        @(posedge clk) supply.logic_ok <= 1'b1;
        idle(5);
        rd_chk(OFS_IN_EN, 32'h0000_00F0);
    endtask : t_logic_loss

    // Source 0 is the reset pin, 1 a supply drop below the power-on level
    task automatic t_reset(input int src);
        wr(OFS_CONFIG, 32'h0000_0000);
        wr(OFS_IN_EN, 32'h0000_0003);
        wr(OFS_CONFIG, 32'h0000_0001);
        @(posedge clk) if (src == 0) supply.reset_pin <= 1'b1; else supply.por_ok <= 1'b0;
        idle(260);
        chk(wet, 0);
        chk(in_en, 0);
        rd_chk(OFS_IN_EN, 32'h0000_0000);
        @(posedge clk) supply <= '{por_ok: 1'b1, reset_pin: 1'b0, uv_low: 1'b0, logic_ok: 1'b1};
        idle(30);
        chk(ev_n, 0);
        rd_chk(OFS_EVENT, 32'h0000_0001);
        rd_chk(OFS_CONFIG, 32'h0000_0000);
        frame(8'h80);
    endtask : t_reset

    initial begin
        reset_n   = 1'b0;
        bus_req   = '0;
        supply    = '{por_ok: 1'b1, reset_pin: 1'b0, uv_low: 1'b0, logic_ok: 1'b1};
        chk_err   = 1'b0;
        poll_done = 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        idle(30);
        t_power_up;
        t_selfcheck;
        t_run_lock;
        t_uv;
        t_logic_loss;
        t_reset(0);
        t_reset(1);
        close_out;
    end
endmodule : switch_monitor_reset_uv_control_bench

`default_nettype wire
